// ---- verilog/alert_update_defines.svh ----
// register offsets, mask address step and reset values for the alert-triggered output update block
`ifndef ALERT_UPDATE_DEFINES_SVH
`define ALERT_UPDATE_DEFINES_SVH

`define OUT0_MASK_ADDR     8'hc3
`define OUT1_MASK_ADDR     8'hc5
`define OUT2_MASK_ADDR     8'hc7
`define OUT3_MASK_ADDR     8'hc9
`define OUT4_MASK_ADDR     8'hcb
`define OUT5_MASK_ADDR     8'hcd
`define OUT6_MASK_ADDR     8'hcf
`define OUT7_MASK_ADDR     8'hd1
`define MASK_ADDR_STEP     8'h02
`define UPDATE_ENABLE_ADDR 8'he9
`define PRESET_LEVEL_ADDR  8'heb
`define MASK_RESET         8'h02
`define UPDATE_EN_RESET    8'h00
`define PRESET_RESET       8'h00
`define OUT_LEVEL_RESET    8'h00

`endif

// ---- verilog/alert_update_pkg.sv ----
// types shared by the alert-triggered output update block
package alert_update_pkg;
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic       rvalid;
      logic [7:0] rdata;
   } reg_rsp_t;
endpackage

// ---- verilog/alert_triggered_output_update.sv ----
// alert-triggered update of the eight digital output pins
//
// How it works
// - every output keeps an 8-bit mask choosing which input channels' alert flags may trigger it.
// - each mask resets to 0x02, so only channel 1 triggers after reset.
// - an 8-bit enable field lets alert triggers update an output only where its bit is 1.
// - an 8-bit preset field gives the level driven onto an output when its trigger occurs.
// - the preset reaches a pin only when that output's enable bit is set.
// - the enable and preset fields both reset to 0x00.
`timescale 1ns/100ps
`include "alert_update_defines.svh"

module alert_triggered_output_update
   import alert_update_pkg::*;
#(
   parameter int NUM_OUT = 8,
   parameter int NUM_CH  = 8
) (
   input  wire logic               ref_clk,
   input  wire logic               sys_rst,
   input  wire reg_req_t           reg_req,
   output reg_rsp_t                reg_rsp,
   input  wire logic [NUM_CH-1:0]  alert_flags,
   output logic      [NUM_OUT-1:0] digital_output_pin,
   output logic      [NUM_OUT-1:0] output_updated
);

   // the register map holds exactly eight outputs of eight channels each
   if (NUM_OUT != 8 || NUM_CH != 8) begin : g_bad_size
      $error("alert_triggered_output_update serves exactly 8 outputs and 8 channels");
   end

   logic [7:0] output_trigger_source_mask_reg  [NUM_OUT];
   logic [7:0] output_trigger_source_mask_next [NUM_OUT];
   logic [7:0] alert_update_enable_reg;
   logic [7:0] alert_update_enable_next;
   logic [7:0] alert_update_preset_level_reg;
   logic [7:0] alert_update_preset_level_next;
   logic [7:0] pin_reg;
   logic [7:0] pin_next;
   logic [7:0] updated_reg;
   logic [7:0] updated_next;
   reg_rsp_t   rsp_reg;
   reg_rsp_t   rsp_next;
   logic [7:0] trigger;

   // register writes
   always_comb begin
      alert_update_enable_next       = alert_update_enable_reg;
      alert_update_preset_level_next = alert_update_preset_level_reg;
      for (int i = 0; i < NUM_OUT; i++) begin
         output_trigger_source_mask_next[i] = output_trigger_source_mask_reg[i];
         if (reg_req.wr_en &&
             reg_req.addr == 8'(`OUT0_MASK_ADDR + 8'(i) * `MASK_ADDR_STEP)) begin
            output_trigger_source_mask_next[i] = reg_req.wdata;
         end
      end
      if (reg_req.wr_en && reg_req.addr == `UPDATE_ENABLE_ADDR) begin
         alert_update_enable_next = reg_req.wdata;
      end
      if (reg_req.wr_en && reg_req.addr == `PRESET_LEVEL_ADDR) begin
         alert_update_preset_level_next = reg_req.wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_OUT; i++) begin
            output_trigger_source_mask_reg[i] <= `MASK_RESET;
         end
         alert_update_enable_reg       <= `UPDATE_EN_RESET;
         alert_update_preset_level_reg <= `PRESET_RESET;
      end else begin
         for (int i = 0; i < NUM_OUT; i++) begin
            output_trigger_source_mask_reg[i] <= output_trigger_source_mask_next[i];
         end
         alert_update_enable_reg       <= alert_update_enable_next;
         alert_update_preset_level_reg <= alert_update_preset_level_next;
      end
   end

   // register reads, answered one cycle after the request
   always_comb begin
      rsp_next.rvalid = reg_req.rd_en;
      rsp_next.rdata  = 8'h00;
      if (reg_req.rd_en) begin
         for (int i = 0; i < NUM_OUT; i++) begin
            if (reg_req.addr == 8'(`OUT0_MASK_ADDR + 8'(i) * `MASK_ADDR_STEP)) begin
               rsp_next.rdata = output_trigger_source_mask_reg[i];
            end
         end
         if (reg_req.addr == `UPDATE_ENABLE_ADDR) begin
            rsp_next.rdata = alert_update_enable_reg;
         end
         if (reg_req.addr == `PRESET_LEVEL_ADDR) begin
            rsp_next.rdata = alert_update_preset_level_reg;
         end
      end
   end

   // output update from alert flags
   always_comb begin
      pin_next     = pin_reg;
      updated_next = 8'h00;
      for (int i = 0; i < NUM_OUT; i++) begin
         trigger[i] = |(alert_flags & output_trigger_source_mask_reg[i]);
         if (trigger[i] && alert_update_enable_reg[i]) begin
            pin_next[i]     = alert_update_preset_level_reg[i];
            updated_next[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_reg     <= `OUT_LEVEL_RESET;
         updated_reg <= 8'h00;
         rsp_reg     <= '0;
      end else begin
         pin_reg     <= pin_next;
         updated_reg <= updated_next;
         rsp_reg     <= rsp_next;
      end
   end

   assign digital_output_pin = pin_reg;
   assign output_updated     = updated_reg;
   assign reg_rsp            = rsp_reg;

   property p_mask_reset;
      @(posedge ref_clk) $fell(sys_rst) |-> output_trigger_source_mask_reg[3] == 8'h02;
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("mask not 0x02 after reset");

   // enable and preset zero after reset
   property p_cfg_reset;
      @(posedge ref_clk) $fell(sys_rst) |->
         alert_update_enable_reg == 8'h00 && alert_update_preset_level_reg == 8'h00;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero after reset");

   property p_mask_write;
      @(posedge ref_clk) disable iff (sys_rst)
         reg_req.wr_en && reg_req.addr == 8'hc9 |=>
         output_trigger_source_mask_reg[3] == $past(reg_req.wdata);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write lost");

   property p_disabled_hold;
      @(posedge ref_clk) disable iff (sys_rst)
         !alert_update_enable_reg[0] |=> digital_output_pin[0] == $past(digital_output_pin[0]);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold) else $error("disabled output moved");

   property p_preset_drive;
      @(posedge ref_clk) disable iff (sys_rst)
         alert_update_enable_reg[2] && |(alert_flags & output_trigger_source_mask_reg[2])
         |=> digital_output_pin[2] == $past(alert_update_preset_level_reg[2]);
   endproperty
   a_preset_drive: assert property (p_preset_drive) else $error("preset not driven");

   property p_update_gated;
      @(posedge ref_clk) disable iff (sys_rst)
         output_updated[5] |-> $past(alert_update_enable_reg[5]);
   endproperty
   a_update_gated: assert property (p_update_gated) else $error("update while disabled");

   property p_hold_no_trigger;
      @(posedge ref_clk) disable iff (sys_rst)
         !(|(alert_flags & output_trigger_source_mask_reg[7])) |=>
         $stable(digital_output_pin[7]) && !output_updated[7];
   endproperty
   a_hold_no_trigger: assert property (p_hold_no_trigger) else $error("untriggered change");

   // read answer follows one cycle later
   property p_read_answer;
      @(posedge ref_clk) disable iff (sys_rst)
         reg_req.rd_en && reg_req.addr == 8'he9 |=>
         reg_rsp.rvalid && reg_rsp.rdata == $past(alert_update_enable_reg);
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("bad enable readback");

   // first and last masks reset too
   property p_mask_reset_ends;
      @(posedge ref_clk) $fell(sys_rst) |->
         output_trigger_source_mask_reg[0] == 8'h02 && output_trigger_source_mask_reg[7] == 8'h02;
   endproperty
   a_mask_reset_ends: assert property (p_mask_reset_ends) else $error("end mask not 0x02");

   // outputs quiet while reset is held
   property p_reset_outputs;
      @(posedge ref_clk) sys_rst |=>
         digital_output_pin == 8'h00 && output_updated == 8'h00 && !reg_rsp.rvalid;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not reset");

   property p_mask_write_last;
      @(posedge ref_clk) disable iff (sys_rst)
         reg_req.wr_en && reg_req.addr == 8'hd1 |=>
         output_trigger_source_mask_reg[7] == $past(reg_req.wdata);
   endproperty
   a_mask_write_last: assert property (p_mask_write_last) else $error("mask 7 write lost");

   property p_update_pulse;
      @(posedge ref_clk) disable iff (sys_rst)
         alert_update_enable_reg[1] && |(alert_flags & output_trigger_source_mask_reg[1])
         |=> output_updated[1];
   endproperty
   a_update_pulse: assert property (p_update_pulse) else $error("enabled output not updated");

   // preset of a disabled output has no effect
   property p_preset_no_effect;
      @(posedge ref_clk) disable iff (sys_rst)
         !alert_update_enable_reg[6] && alert_update_preset_level_reg[6] |=>
         digital_output_pin[6] == $past(digital_output_pin[6]) && !output_updated[6];
   endproperty
   a_preset_no_effect: assert property (p_preset_no_effect) else $error("disabled preset leaked");

   property p_unmapped_read;
      @(posedge ref_clk) disable iff (sys_rst)
         reg_req.rd_en && reg_req.addr == 8'hc4 |=> reg_rsp.rvalid && reg_rsp.rdata == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_rsp_idle;
      @(posedge ref_clk) disable iff (sys_rst)
         !reg_req.rd_en |=> !reg_rsp.rvalid && reg_rsp.rdata == 8'h00;
   endproperty
   a_rsp_idle: assert property (p_rsp_idle) else $error("answer without read");

endmodule

// ---- bench/host_model.sv ----
// host model issuing register accesses on the parallel register port
`timescale 1ns/100ps

module host_model
   import alert_update_pkg::*;
(
   input  wire logic     ref_clk,
   output reg_req_t      reg_req,
   input  wire reg_rsp_t reg_rsp
);
   initial reg_req = '0;

   // one access; a read answers in the cycle after it is taken
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge ref_clk);
      #1;
      reg_req = '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
      @(posedge ref_clk);
      #1;
      q = (reg_rsp.rvalid === 1'b1) ? reg_rsp.rdata : 8'hxx;
      // released bus shows no stale address or data
      reg_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the alert-triggered output update block
`timescale 1ns/100ps
`include "alert_update_defines.svh"

module testbench;
   import alert_update_pkg::*;
   logic       ref_clk;
   logic       sys_rst;
   reg_req_t   reg_req;
   reg_rsp_t   reg_rsp;
   logic [7:0] alert_flags;
   logic [7:0] digital_output_pin;
   logic [7:0] output_updated;
   logic [7:0] q;
   logic [7:0] ex;
   logic [7:0] pr;
   int         fail_count;
   int         checks_done;
   int         cycles;

   alert_triggered_output_update alert_triggered_output_update_i (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
      .alert_flags(alert_flags), .digital_output_pin(digital_output_pin),
      .output_updated(output_updated));
   host_model host_model_i (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rsp(reg_rsp));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict;
      if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   function automatic logic [7:0] ma(input int i);
      return `OUT0_MASK_ADDR + 8'(2 * i);
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_model_i.access(1'b1, a, d, q);
   endtask

   task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
      host_model_i.access(1'b0, a, 8'h00, q);
      check(what, q, exp);
   endtask

   // flags held for one edge, then pins and pulses looked at
   task automatic fire(input logic [7:0] f, input logic [7:0] ep, input logic [7:0] eu);
      @(posedge ref_clk);
      #1 alert_flags = f;
      @(posedge ref_clk);
      #1 alert_flags = 8'h00;
      check("pins", digital_output_pin, ep);
      check("updated", output_updated, eu);
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles > 3000) begin
         fail_count++;
         print_verdict();
      end
   end

   initial begin
      alert_flags = 8'h00;
      sys_rst = 1'b1;
      fail_count = 0;
      checks_done = 0;
      cycles = 0;
      repeat (2) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      check("pins at reset", digital_output_pin, 8'h00);
      for (int i = 0; i < 8; i++) rc("mask reset", ma(i), 8'h02);
      rc("enable reset", `UPDATE_ENABLE_ADDR, 8'h00);
      rc("preset reset", `PRESET_LEVEL_ADDR, 8'h00);
      fire(8'h02, 8'h00, 8'h00);
      wr(`UPDATE_ENABLE_ADDR, 8'hff);
      rc("enable", `UPDATE_ENABLE_ADDR, 8'hff);
      rc("unmapped", 8'hc4, 8'h00);
      for (int i = 0; i < 8; i++) wr(ma(i), 8'h01 << i);
      for (int i = 0; i < 8; i++) rc("mask", ma(i), 8'h01 << i);
      ex = 8'h00;
      for (int k = 0; k < 2; k++) begin
         pr = k ? 8'h5a : 8'ha5;
         wr(`PRESET_LEVEL_ADDR, pr);
         rc("preset", `PRESET_LEVEL_ADDR, pr);
         for (int i = 0; i < 8; i++) begin
            ex = (ex & ~(8'h01 << i)) | (pr & (8'h01 << i));
            fire(8'h01 << i, ex, 8'h01 << i);
         end
      end
      // only enabled outputs take the preset
      wr(`UPDATE_ENABLE_ADDR, 8'h0f);
      wr(`PRESET_LEVEL_ADDR, 8'h00);
      fire(8'hff, 8'h50, 8'h0f);
      wr(ma(0), 8'hfe);
      wr(`PRESET_LEVEL_ADDR, 8'hff);
      fire(8'h01, 8'h50, 8'h00);
      fire(8'h80, 8'h51, 8'h01);
      // mid-run reset brings every register back to its reset value
      @(posedge ref_clk);
      #1 sys_rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      check("pins after reset", digital_output_pin, 8'h00);
      check("updated after reset", output_updated, 8'h00);
      for (int i = 0; i < 8; i++) rc("mask re-reset", ma(i), 8'h02);
      rc("enable re-reset", `UPDATE_ENABLE_ADDR, 8'h00);
      rc("preset re-reset", `PRESET_LEVEL_ADDR, 8'h00);
      fire(8'h02, 8'h00, 8'h00);
      print_verdict();
   end
endmodule
